// ### design/uatc_defs.svh
`ifndef UATC_DEFS_SVH
`define UATC_DEFS_SVH
// register byte offsets on the wishbone slave
`define UATC_OFF_TOGGLE   6'h00
`define UATC_OFF_ENH      6'h04
`define UATC_OFF_STOPCHR  6'h08
`define UATC_OFF_UPPER    6'h0C
`define UATC_ADR_LOWER    6'h10
`define UATC_ADR_IRQSTAT  6'h14
`define UATC_ADR_IRQMASK  6'h18
`define UATC_ADR_PROT     6'h1C
// toggle control field positions
`define UATC_TG_RXPOL     7
`define UATC_TG_RXMODE    6
`define UATC_TG_TXPOL     5
`define UATC_TG_TXMODE    4
`define UATC_TG_USED_MASK 8'hF3
`define UATC_TG_RESET     8'h80
// enhanced feature field positions
`define UATC_EF_CTS       7
`define UATC_EF_RTS       6
`define UATC_EF_SPC       5
`define UATC_EF_ENH       4
`define UATC_EF_RESET     8'h00
// threshold reset values
`define UATC_UPPER_RESET  8'hC0
`define UATC_LOWER_RESET  8'h40
// special character reset value
`define UATC_STOP_RESET   8'h00
// interrupt status bits
`define UATC_IRQ_SPC      0
`define UATC_IRQ_RTS      1
`define UATC_IRQ_CTS      2
`define UATC_IRQ_W        3
// protected bit images
`define UATC_PROT_RESET   8'h00
`endif

// ### design/uatc_pkg.sv
package uatc_pkg;
  // auto toggle pin routing modes
  typedef enum logic [1:0] {
    UATC_TG_OFF  = 2'b00,
    UATC_TG_RTS  = 2'b01,
    UATC_TG_DTR  = 2'b10,
    UATC_TG_RDY  = 2'b11
  } uatc_toggle_type;
  // transmitter activity states
  typedef enum logic [2:0] {
    UATC_ST_IDLE = 3'b001,
    UATC_ST_SEND = 3'b010,
    UATC_ST_HALT = 3'b100
  } uatc_tx_state_type;
endpackage

// ### design/uatc_sync.sv
`timescale 1ns/1ps
// two flop synchroniser for pin inputs
module uatc_sync (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // level
  input  wire logic pin_in,
  output logic      pin_sync
);
  logic meta_q;
  // first flop feeds only the second
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q   <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule

// ### design/uatc_core.sv
`timescale 1ns/1ps
`include "uatc_defs.svh"
module uatc_core (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // transmitter side
  input  wire logic        tx_start,
  input  wire logic        tx_all_empty,
  output logic             tx_allow,
  // receiver side
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic [8:0]  rx_fifo_count,
  output logic             rx_char_store,
  // normal pin functions from the uart
  input  wire logic        rts_normal,
  input  wire logic        dtr_normal,
  input  wire logic        tx_ready_normal,
  input  wire logic        rx_ready_normal,
  // modem pins
  input  wire logic        cts_n_pin,
  output logic             rts_pin,
  output logic             dtr_pin,
  output logic             tx_ready_out,
  output logic             rx_ready_out,
  // decoded controls
  output logic [3:0]       sw_flow_select,
  output logic [7:0]       prot_bits,
  output logic             irq
);
  import uatc_pkg::*;

  logic [7:0] toggle_q;
  logic [7:0] enh_q;
  logic [7:0] stop_q;
  logic [7:0] upper_q;
  logic [7:0] lower_q;
  logic [7:0] prot_q;
  wire  [`UATC_IRQ_W-1:0] stat_q;
  logic [`UATC_IRQ_W-1:0] mask_q;
  logic       ack_q;
  logic [31:0] rdat_q;
  logic       rts_hold_q;
  logic       rts_hold_d;
  logic       cts_sync;
  uatc_tx_state_type st_q;
  uatc_tx_state_type st_d;

  // cts pin crosses in through two flops
  uatc_sync u_cts_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .pin_in   (cts_n_pin),
    .pin_sync (cts_sync)
  );

  // bus decode
  wire req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr       = req & wb_we_i & wb_sel_i[0];
  wire hit_tg   = wb_adr_i == `UATC_OFF_TOGGLE;
  wire hit_ef   = wb_adr_i == `UATC_OFF_ENH;
  wire hit_sc   = wb_adr_i == `UATC_OFF_STOPCHR;
  wire hit_up   = wb_adr_i == `UATC_OFF_UPPER;
  wire hit_lo   = wb_adr_i == `UATC_ADR_LOWER;
  wire hit_st   = wb_adr_i == `UATC_ADR_IRQSTAT;
  wire hit_mk   = wb_adr_i == `UATC_ADR_IRQMASK;
  wire hit_pr   = wb_adr_i == `UATC_ADR_PROT;
  wire enh_on   = enh_q[`UATC_EF_ENH];
  wire [7:0] wd = wb_dat_i[7:0];

  // register read mux, unmapped reads zero
  wire [7:0] rmux =
    hit_tg ? (toggle_q & `UATC_TG_USED_MASK) :
    hit_ef ? enh_q :
    hit_sc ? stop_q :
    hit_up ? upper_q :
    hit_lo ? lower_q :
    hit_st ? {5'h00, stat_q} :
    hit_mk ? {5'h00, mask_q} :
    hit_pr ? prot_q : 8'h00;

  // ack one cycle after request, drops next
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req;
      rdat_q <= {24'h00_0000, rmux};
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // control register writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      toggle_q <= `UATC_TG_RESET;
      enh_q    <= `UATC_EF_RESET;
      stop_q   <= `UATC_STOP_RESET;
      upper_q  <= `UATC_UPPER_RESET;
      lower_q  <= `UATC_LOWER_RESET;
      mask_q   <= 3'h0;
    end else begin
      if (wr && hit_tg) toggle_q <= wd & `UATC_TG_USED_MASK;
      if (wr && hit_ef) enh_q <= wd;
      if (wr && hit_sc) stop_q <= wd;
      if (wr && hit_up) upper_q <= wd;
      if (wr && hit_lo) lower_q <= wd;
      if (wr && hit_mk) mask_q <= wd[`UATC_IRQ_W-1:0];
    end
  end

  // protected bits change only while enhanced bit is set
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) prot_q <= `UATC_PROT_RESET;
    else if (wr && hit_pr && enh_on) prot_q <= wd;
  end
  assign prot_bits      = enh_on ? prot_q : 8'h00;
  assign sw_flow_select = enh_q[3:0];

  // transmitter activity tracking
  wire cts_en   = enh_q[`UATC_EF_CTS];
  wire cts_stop = cts_en & cts_sync;
  always_comb begin
    st_d = st_q;
    case (st_q)
      UATC_ST_IDLE: if (tx_start && !cts_stop) st_d = UATC_ST_SEND;
      UATC_ST_SEND: begin
        if (tx_all_empty) st_d = UATC_ST_IDLE;
      end
      UATC_ST_HALT: if (!cts_stop) st_d = UATC_ST_IDLE;
      default:      st_d = UATC_ST_IDLE;
    endcase
    // a start asked for under cts parks in halt
    if (st_q == UATC_ST_IDLE && tx_start && cts_stop) st_d = UATC_ST_HALT;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) st_q <= UATC_ST_IDLE;
    else st_q <= st_d;
  end
  // new characters are not started while auto cts is enabled and cts is high
  assign tx_allow = ~cts_stop;
  wire sending = st_q == UATC_ST_SEND;

  // line driver enables
  wire rx_pol  = toggle_q[`UATC_TG_RXPOL];
  wire tx_pol  = toggle_q[`UATC_TG_TXPOL];
  wire rx_mode = toggle_q[`UATC_TG_RXMODE];
  wire tx_mode = toggle_q[`UATC_TG_TXMODE];
  wire [1:0] tg_field = toggle_q[1:0];
  // tx enable sits at polarity unless mode toggles it with activity
  wire tx_en   = tx_mode ? (sending ? tx_pol : ~tx_pol) :
                 tx_pol;
  // rx enable only toggles on the ready pins
  wire rx_en   = (rx_mode && tg_field == UATC_TG_RDY && sending) ?
                 ~rx_pol : rx_pol;

  // auto rts hysteresis
  wire rts_en  = enh_q[`UATC_EF_RTS];
  always_comb begin
    rts_hold_d = rts_hold_q;
    if (rx_fifo_count > {1'b0, upper_q}) rts_hold_d = 1'b1;
    else if (rx_fifo_count < {1'b0, lower_q}) rts_hold_d = 1'b0;
    if (!rts_en) rts_hold_d = 1'b0;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rts_hold_q <= 1'b0;
    else rts_hold_q <= rts_hold_d;
  end
  // auto rts replaces the uart's own request line
  wire rts_fn = rts_en ? rts_hold_q : rts_normal;

  // pin multiplexing by toggle field
  assign rts_pin      = (tg_field == UATC_TG_RTS) ? tx_en :
                        rts_fn;
  assign dtr_pin      = (tg_field == UATC_TG_DTR) ? tx_en :
                        dtr_normal;
  assign tx_ready_out = (tg_field == UATC_TG_RDY) ? tx_en :
                        tx_ready_normal;
  assign rx_ready_out = (tg_field == UATC_TG_RDY) ? rx_en :
                        rx_ready_normal;

  // special character match; character always stored
  wire spc_hit = enh_q[`UATC_EF_SPC] & rx_char_valid &
                 (rx_char == stop_q);
  assign rx_char_store = rx_char_valid;

  // sticky status, set wins over write one clear
  logic rts_hold_p;
  logic cts_stop_p;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rts_hold_p <= 1'b0;
      cts_stop_p <= 1'b0;
    end else begin
      rts_hold_p <= rts_hold_q;
      cts_stop_p <= cts_stop;
    end
  end
  wire [`UATC_IRQ_W-1:0] ev = {cts_stop & ~cts_stop_p,
                               rts_hold_q & ~rts_hold_p, spc_hit};
  wire [`UATC_IRQ_W-1:0] clr = (wr && hit_st) ? wd[`UATC_IRQ_W-1:0] : 3'h0;
  // one sticky bit per event, a set beats a write one clear
  genvar gi;
  for (gi = 0; gi < `UATC_IRQ_W; gi++) begin : g_stat
    logic sticky_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) sticky_q <= 1'b0;
      else if (ev[gi]) sticky_q <= 1'b1;
      else if (clr[gi]) sticky_q <= 1'b0;
    end
    assign stat_q[gi] = sticky_q;
  end
  // level interrupt from unmasked sticky bits
  assign irq = |(stat_q & mask_q);

  // auto rts hysteresis checks
  chk_rts_upper: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    rts_en && rx_fifo_count > {1'b0, upper_q} |=> rts_hold_q)
    else $error("rts not raised above upper");
  chk_rts_lower: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    rts_en && rx_fifo_count < {1'b0, lower_q} &&
    rx_fifo_count <= {1'b0, upper_q} |=> !rts_hold_q)
    else $error("rts not dropped below lower");
  chk_rts_off: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !rts_en |=> !rts_hold_q)
    else $error("rts hold set while auto rts off");
  chk_rts_event: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(rts_hold_q) |=> stat_q[`UATC_IRQ_RTS])
    else $error("rts rise not flagged");
  // unused toggle bits never stored
  chk_tog_zero: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    toggle_q[3:2] == 2'b00)
    else $error("toggle bits 3:2 nonzero");
  // protected image frozen while locked
  chk_prot_lock: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !enh_on |=> $stable(prot_q))
    else $error("protected bits changed while locked");
  // special character flagged and held until cleared
  chk_spc_flag: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    spc_hit |=> stat_q[`UATC_IRQ_SPC])
    else $error("special char not flagged");
  chk_spc_hold: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    stat_q[`UATC_IRQ_SPC] && !clr[`UATC_IRQ_SPC] |=>
    stat_q[`UATC_IRQ_SPC])
    else $error("special char flag lost");
  // auto cts blocks starts and keeps the halt
  chk_cts_halt: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    cts_en && cts_sync |-> !tx_allow)
    else $error("sending allowed with cts high");
  chk_halt_stay: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    st_q == UATC_ST_HALT && cts_stop |=> st_q == UATC_ST_HALT)
    else $error("halt left while cts high");
  chk_cts_event: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    cts_en && $rose(cts_sync) |=> stat_q[`UATC_IRQ_CTS])
    else $error("cts rise not flagged");
  // sending ends once the shifter is empty
  chk_send_end: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    sending && tx_all_empty |=> !sending)
    else $error("sending outlived empty shifter");
  // enables on the routed pins
  chk_tx_driver_enable_out_idle: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    tg_field == UATC_TG_RTS && tx_mode && !sending |-> rts_pin == !tx_pol)
    else $error("tx enable wrong while idle");
  chk_tx_driver_enable_out_send: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    tg_field == UATC_TG_RTS && tx_mode && sending |-> rts_pin == tx_pol)
    else $error("tx enable wrong while sending");
  chk_tx_driver_enable_out_dtr: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    tg_field == UATC_TG_DTR && !tx_mode |-> dtr_pin == tx_pol)
    else $error("dtr pin not at tx polarity");
  chk_rx_driver_enable_out_fixed: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    tg_field == UATC_TG_RDY && !rx_mode |-> rx_ready_out == rx_pol)
    else $error("rx enable not at polarity");
  chk_rx_driver_enable_out_send: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    tg_field == UATC_TG_RDY && rx_mode && sending |->
    rx_ready_out == !rx_pol)
    else $error("rx enable not inverted while sending");
  // normal dtr and tx ready functions kept with toggling off
  chk_normal_pins: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    tg_field == UATC_TG_OFF |-> dtr_pin == dtr_normal &&
    tx_ready_out == tx_ready_normal)
    else $error("normal pin function lost");
  // bus answer is a single cycle pulse
  chk_ack_drop: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ack_q |=> !ack_q)
    else $error("ack held two cycles");
  // main scenarios reached
  cov_send: cover property (@(posedge ref_clk) disable iff (!rstn)
    st_q == UATC_ST_IDLE ##1 st_q == UATC_ST_SEND);
  cov_halt: cover property (@(posedge ref_clk) disable iff (!rstn)
    st_q == UATC_ST_HALT);
  cov_spc: cover property (@(posedge ref_clk) disable iff (!rstn) spc_hit);
  cov_irq: cover property (@(posedge ref_clk) disable iff (!rstn) irq);
  cov_rts: cover property (@(posedge ref_clk) disable iff (!rstn)
    $rose(rts_hold_q));
endmodule

// ### verification/uatc_far_model.sv
`timescale 1ns/1ps
// remote modem: answers a hold-off request on its clear-to-send line
module uatc_far_model (
  // clock
  input  wire logic ref_clk,
  // control from the bench
  input  wire logic hold_off,
  input  wire logic slow,
  // modem line
  output logic      cts_n_pin
);
  logic [2:0] lag_q;
  // delay chain models a prompt or a slow remote
  always_ff @(posedge ref_clk) begin
    lag_q <= {lag_q[1:0], hold_off};
  end
  // high asks our side to stop, low lets it resume
  assign cts_n_pin = slow ? lag_q[2] : lag_q[0];
endmodule

// ### verification/uart_auto_toggle_flow_ctrl_bench.sv
`timescale 1ns/1ps
`include "uatc_defs.svh"
`define CHK(g,e) begin check_count++; if ((g)!==(e)) begin \
  miscompares++; $display("Error t=%0t got=%0h exp=%0h",$time,g,e); end end
module uart_auto_toggle_flow_ctrl_bench;
  import uatc_pkg::*;
  logic        ref_clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
  logic [5:0]  adr = 0;
  logic [31:0] wdat = 0, rd, q;
  logic        ack, tx_start = 0, tx_empty = 1, tx_allow;
  logic        rx_v = 0, store, irq, rts, dtr, txr, rxr;
  logic [7:0]  rx_char = 0, prot;
  logic [8:0]  cnt = 0;
  logic [3:0]  nrm = 0, sw;
  logic        hold_off = 0, slow = 0, cts_n;
  int          miscompares = 0, check_count = 0, cycles = 0, t;
  logic [7:0]  t_chars [2] = '{8'hA5, 8'h5A};
  always #5 ref_clk = ~ref_clk;
  uatc_far_model far_u (.ref_clk(ref_clk), .hold_off(hold_off),
    .slow(slow), .cts_n_pin(cts_n));
  uatc_core dut_u (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack), .tx_start(tx_start),
    .tx_all_empty(tx_empty), .tx_allow(tx_allow), .rx_char_valid(rx_v),
    .rx_char(rx_char), .rx_fifo_count(cnt), .rx_char_store(store),
    .rts_normal(nrm[3]), .dtr_normal(nrm[2]), .tx_ready_normal(nrm[1]),
    .rx_ready_normal(nrm[0]), .cts_n_pin(cts_n), .rts_pin(rts),
    .dtr_pin(dtr), .tx_ready_out(txr), .rx_ready_out(rxr),
    .sw_flow_select(sw), .prot_bits(prot), .irq(irq));
  // one classic wishbone cycle, held until ack
  // registers reached directly, page unlock is upstream
  task automatic wb(input logic w, input logic [5:0] a,
                    input logic [7:0] d);
    @(posedge ref_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {24'h0, d};
    do @(posedge ref_clk); while (ack !== 1'b1);
    q = rd;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // expected pins {rts,dtr,txr,rxr} for toggle value and activity
  function automatic logic [3:0] pins(input int v, input int s,
                                      input logic [3:0] n);
    int tx, rx;
    tx = ((v>>4)&1) ? (s ? (v>>5)&1 : ~(v>>5)&1) : (v>>5)&1;
    rx = ((v&3)==3 && ((v>>6)&1) && s) ? ~(v>>7)&1 : (v>>7)&1;
    pins = n;
    if ((v&3)==1) pins[3] = tx[0];
    if ((v&3)==2) pins[2] = tx[0];
    if ((v&3)==3) begin pins[1] = tx[0]; pins[0] = rx[0]; end
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin miscompares++; report_and_stop; end
  end
  initial begin
    void'($urandom(32'hC171));
    repeat (4) @(posedge ref_clk);
    rstn <= 1;
    wb(0, `UATC_OFF_TOGGLE, 0); `CHK(q, 32'h80)
    wb(0, `UATC_OFF_ENH, 0);    `CHK(q, 32'h00)
    wb(0, 6'h3C, 0);            `CHK(q, 32'h00)
    wb(1, `UATC_OFF_TOGGLE, 8'hFF);
    wb(0, `UATC_OFF_TOGGLE, 0); `CHK(q, 32'hF3)
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      t = {24'h000000, 4'($urandom()), 2'b00, i[1:0]};
      nrm <= 4'($urandom());
      wb(1, `UATC_OFF_TOGGLE, 8'(t));
      edges(1); `CHK({rts,dtr,txr,rxr}, pins(t, 0, nrm))
      @(posedge ref_clk); tx_start <= 1; tx_empty <= 0;
      @(posedge ref_clk); tx_start <= 0;
      edges(1); `CHK({rts,dtr,txr,rxr}, pins(t, 1, nrm))
      @(posedge ref_clk); tx_empty <= 1;
      edges(2); `CHK({rts,dtr,txr,rxr}, pins(t, 0, nrm))
    end
    $display("test routing done");
    wb(1, `UATC_OFF_TOGGLE, 8'h80);
    wb(1, `UATC_ADR_IRQMASK, 8'h07);
    wb(1, `UATC_OFF_ENH, 8'h80);
    slow <= 1; hold_off <= 1;
    edges(8); `CHK(tx_allow, 1'b0)
    wb(0, `UATC_ADR_IRQSTAT, 0); `CHK(q, 32'h4)
    edges(0); `CHK(irq, 1'b1)
    wb(1, `UATC_OFF_TOGGLE, 8'h31);
    @(posedge ref_clk); tx_start <= 1; tx_empty <= 0;
    @(posedge ref_clk); tx_start <= 0;
    edges(1); `CHK(rts, 1'b0)
    @(posedge ref_clk); hold_off <= 0; tx_empty <= 1;
    edges(8); `CHK(tx_allow, 1'b1)
    `CHK(rts, 1'b0)
    wb(1, `UATC_OFF_TOGGLE, 8'h80);
    wb(1, `UATC_ADR_IRQSTAT, 8'h04); edges(1); `CHK(irq, 1'b0)
    $display("test cts done");
    wb(1, `UATC_OFF_UPPER, 8'hC0);
    wb(1, `UATC_ADR_LOWER, 8'h40);
    wb(0, `UATC_ADR_LOWER, 0);  `CHK(q, 32'h40)
    wb(1, `UATC_OFF_ENH, 8'h40);
    cnt <= 9'h0C1; edges(3); `CHK(rts, 1'b1)
    cnt <= 9'h040; edges(3); `CHK(rts, 1'b1)
    cnt <= 9'h03F; edges(3); `CHK(rts, 1'b0)
    wb(0, `UATC_ADR_IRQSTAT, 0); `CHK(q, 32'h2)
    wb(1, `UATC_ADR_IRQSTAT, 8'h02);
    $display("test rts done");
    wb(1, `UATC_OFF_STOPCHR, 8'h5A);
    wb(1, `UATC_OFF_ENH, 8'h20);
    foreach (t_chars[k]) begin
      @(posedge ref_clk); rx_char <= t_chars[k]; rx_v <= 1;
      @(negedge ref_clk); `CHK(store, 1'b1)
      @(posedge ref_clk); rx_v <= 0;
      edges(1); `CHK(irq, k[0])
    end
    wb(0, `UATC_ADR_IRQSTAT, 0); `CHK(q, 32'h1)
    wb(1, `UATC_ADR_IRQMASK, 8'h00); edges(1); `CHK(irq, 1'b0)
    wb(1, `UATC_ADR_IRQSTAT, 8'h01);
    wb(0, `UATC_ADR_IRQSTAT, 0); `CHK(q, 32'h0)
    $display("test special char done");
    wb(1, `UATC_OFF_ENH, 8'h00);
    wb(1, `UATC_ADR_PROT, 8'hFF);
    wb(0, `UATC_ADR_PROT, 0); `CHK(q, 32'h0)
    wb(1, `UATC_OFF_ENH, 8'h1B);
    wb(1, `UATC_ADR_PROT, 8'hA5);
    wb(0, `UATC_ADR_PROT, 0); `CHK(q, 32'hA5)
    edges(1); `CHK(prot, 8'hA5)
    `CHK(sw, 4'hB)
    $display("test protect done");
    report_and_stop;
  end
endmodule
